// ==== logic/xcvr_term.sv ====
// Line termination decode, serial transmit and receive selection logic
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps

// Notes on behaviour
// - Resistor setup comes from select, termination, mode and pull-down bits.
// - Five enables: two pull-ups, two pull-downs, fast termination.
// - Mode 01b clears every resistor enable.
// - Power-up setting enables only the two pull-downs.
// - Host chirp, fast and test: pull-downs plus fast termination.
// - Host full/low speed, suspend, resume: only both pull-downs.
// - Peripheral chirp and full speed states: only plus line pull-up.
// - Peripheral fast or test: only fast termination.
// - Peripheral low speed states: only minus line pull-up.
// - OTG peripheral chirp/full speed: plus pull-up and minus pull-down.
// - OTG peripheral fast or test: termination and minus pull-down.
// - Any unlisted combination clears all five enables.
// - Transmit data is NRZI encoded, bit stuffed and serialized.
// - Receive stream taken from fast or full/low receiver by mode.
// - Full speed line state from the two single-ended receivers.
// - Squelch blocks fast receive data so noise is not taken.
// - Boost bits from software steer the fast transmit amplitude.
// - No upstream hub port termination setting is provided.
// - All logic runs on the single interface clock.
module xcvr_term
  import xcvr_term_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  RST_B,
  // AXI4-Lite slave
  input  wire logic [7:0]            S_AWADDR,
  input  wire logic                  S_AWVALID,
  output logic                       S_AWREADY,
  input  wire logic [31:0]           S_WDATA,
  input  wire logic [3:0]            S_WSTRB,
  input  wire logic                  S_WVALID,
  output logic                       S_WREADY,
  output logic [1:0]                 S_BRESP,
  output logic                       S_BVALID,
  input  wire logic                  S_BREADY,
  input  wire logic [7:0]            S_ARADDR,
  input  wire logic                  S_ARVALID,
  output logic                       S_ARREADY,
  output logic [31:0]                S_RDATA,
  output logic [1:0]                 S_RRESP,
  output logic                       S_RVALID,
  input  wire logic                  S_RREADY,
  // Transmit byte stream
  input  wire logic [7:0]            TX_DATA,
  input  wire logic                  TX_VALID,
  output logic                       TX_READY,
  // Serial line driver side
  output logic                       TX_SERIAL,
  output logic                       TX_ACTIVE,
  output logic                       TX_FAST_SEL,
  output logic [xcvr_term_pkg::BOOST_W-1:0] TX_AMPLITUDE,
  // Receivers
  input  wire logic                  RX_FAST_DATA,
  input  wire logic                  RX_FAST_SQUELCH,
  input  wire logic                  RX_SLOW_DATA,
  input  wire logic                  RX_PLUS_SE,
  input  wire logic                  RX_MINUS_SE,
  output logic                       RX_SERIAL,
  output logic                       RX_SERIAL_VALID,
  output logic [1:0]                 LINE_STATE,
  // Resistor enables
  output xcvr_term_pkg::term_en_t    TERM_EN
);
  import xcvr_term_pkg::*;

  func_ctrl_t           func_q;
  logic [2:0]           otg_q;
  logic [BOOST_W-1:0]   boost_q;
  term_en_t             term_d;
  term_en_t             term_q;
  logic                 aw_held_q;
  logic                 w_held_q;
  logic [7:0]           awaddr_q;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;
  logic                 do_write;
  logic                 addr_ok;
  logic [31:0]          rdata_d;
  logic                 rd_ok;
  logic                 dp_req;
  logic                 dm_req;
  logic                 fast_mode;

  // Write channels taken independently, response once both are held
  assign S_AWREADY = !aw_held_q && !S_BVALID;
  assign S_WREADY  = !w_held_q && !S_BVALID;
  assign do_write  = aw_held_q && w_held_q && !S_BVALID;
  assign addr_ok   = (awaddr_q == FUNC_CTRL_OFS) ||
                     (awaddr_q == OTG_CTRL_OFS) ||
                     (awaddr_q == TX_BOOST_OFS);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      S_BVALID  <= 1'b0;
      S_BRESP   <= RESP_OKAY;
    end else begin
      if (S_AWVALID && S_AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= S_AWADDR;
      end
      if (S_WVALID && S_WREADY) begin
        w_held_q <= 1'b1;
        wdata_q  <= S_WDATA;
        wstrb_q  <= S_WSTRB;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        S_BVALID  <= 1'b1;
        S_BRESP   <= addr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_BVALID && S_BREADY) begin
        S_BVALID <= 1'b0;
      end
    end
  end

  // Control registers; only byte lane 0 carries fields
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      func_q  <= func_ctrl_t'(FUNC_CTRL_RST);
      otg_q   <= OTG_CTRL_RST;
      boost_q <= TX_BOOST_RST;
    end else if (do_write && wstrb_q[0]) begin
      unique case (awaddr_q)
        FUNC_CTRL_OFS: func_q  <= func_ctrl_t'(wdata_q[4:0]);
        OTG_CTRL_OFS:  otg_q   <= wdata_q[2:0];
        TX_BOOST_OFS:  boost_q <= wdata_q[BOOST_LSB +: BOOST_W];
        default: ;
      endcase
    end
  end

  // Read mux; status word shows live enables and line state
  always_comb begin
    rdata_d = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (S_ARADDR)
      FUNC_CTRL_OFS: rdata_d[4:0] = func_q;
      OTG_CTRL_OFS:  rdata_d[2:0] = otg_q;
      TX_BOOST_OFS:  rdata_d[BOOST_W-1:0] = boost_q;
      LINE_STAT_OFS: rdata_d[7:0] = {1'b0, LINE_STATE, term_q};
      default:       rd_ok = 1'b0;
    endcase
  end

  assign S_ARREADY = !S_RVALID;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_RVALID <= 1'b0;
      S_RDATA  <= 32'h0000_0000;
      S_RRESP  <= RESP_OKAY;
    end else if (S_ARVALID && S_ARREADY) begin
      S_RVALID <= 1'b1;
      S_RDATA  <= rdata_d;
      S_RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_RVALID && S_RREADY) begin
      S_RVALID <= 1'b0;
    end
  end

  // Termination table; unlisted settings fall to all-off.
  // No upstream hub row exists, so that role gets all-off too.
  assign dp_req = otg_q[DP_PULL_BIT];
  assign dm_req = otg_q[DM_PULL_BIT];

  always_comb begin
    logic [1:0] xs;
    logic       ts;
    logic [1:0] om;
    logic       run;
    xs  = func_q.transceiver_select;
    ts  = func_q.termination_select;
    om  = func_q.operating_mode;
    run = (om == OPM_NORM) || (om == OPM_NODRV);
    term_d = '0;
    if (om == OPM_TRIST) begin
      term_d = '0;
    end else if (dp_req && dm_req) begin
      if (xs == XCVR_FS && !ts && om == OPM_NORM) begin
        term_d.plus_line_low_pull_on  = 1'b1;
        term_d.minus_line_low_pull_on = 1'b1;
      end else if (xs == XCVR_HS && !ts && run) begin
        term_d.plus_line_low_pull_on    = 1'b1;
        term_d.minus_line_low_pull_on   = 1'b1;
        term_d.fast_line_termination_on = 1'b1;
      end else if (ts && xs != XCVR_HS && run) begin
        term_d.plus_line_low_pull_on  = 1'b1;
        term_d.minus_line_low_pull_on = 1'b1;
      end
    end else if (!dp_req) begin
      // Peripheral rows, with the minus pull-down added for OTG; the low speed row excludes OTG
      if (ts && ((xs == XCVR_HS && om == OPM_NODRV) ||
                 (xs == XCVR_FS && run))) begin
        term_d.plus_line_high_pull_on = 1'b1;
        term_d.minus_line_low_pull_on = dm_req;
      end else if (!ts && xs == XCVR_HS && run) begin
        term_d.fast_line_termination_on = 1'b1;
        term_d.minus_line_low_pull_on   = dm_req;
      end else if (!dm_req && ts && xs == XCVR_LS && run) begin
        term_d.minus_line_high_pull_on = 1'b1;
      end
    end
  end

  // Registered so enables move one edge after the controlling write
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      term_q <= '0;
    end else begin
      term_q <= term_d;
    end
  end

  assign TERM_EN      = term_q;
  assign fast_mode    = (func_q.transceiver_select == XCVR_HS);
  assign TX_FAST_SEL  = fast_mode;
  assign TX_AMPLITUDE = boost_q;

  // Receive path: pick the receiver; squelch masks fast-mode noise
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RX_SERIAL       <= 1'b0;
      RX_SERIAL_VALID <= 1'b0;
      LINE_STATE      <= 2'h0;
    end else begin
      RX_SERIAL <= fast_mode ? RX_FAST_DATA : RX_SLOW_DATA;
      RX_SERIAL_VALID <= fast_mode ? !RX_FAST_SQUELCH : 1'b1;
      LINE_STATE <= {RX_MINUS_SE, RX_PLUS_SE};
    end
  end

  // Transmit: NRZI encode with a stuffed zero after six ones
  tx_state_t  tx_state_q;
  logic [7:0] tx_shift_q;
  logic [2:0] tx_bit_q;
  logic [2:0] ones_q;
  logic       stuff;

  assign stuff    = (ones_q == 3'd6);
  assign TX_READY = (tx_state_q == TX_IDLE) ||
                    (tx_state_q == TX_SHIFT && tx_bit_q == 3'd7 && !stuff);
  assign TX_ACTIVE = (tx_state_q != TX_IDLE);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 8'h00;
      tx_bit_q   <= 3'd0;
      ones_q     <= 3'd0;
      TX_SERIAL  <= 1'b1;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: begin
          ones_q    <= 3'd0;
          TX_SERIAL <= 1'b1;
          if (TX_VALID) begin
            tx_shift_q <= TX_DATA;
            tx_bit_q   <= 3'd0;
            tx_state_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (stuff) begin
            TX_SERIAL <= !TX_SERIAL;
            ones_q    <= 3'd0;
          end else begin
            // A zero toggles the line, a one holds it
            TX_SERIAL  <= tx_shift_q[0] ? TX_SERIAL : !TX_SERIAL;
            ones_q     <= tx_shift_q[0] ? ones_q + 3'd1 : 3'd0;
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_bit_q   <= tx_bit_q + 3'd1;
            if (tx_bit_q == 3'd7) begin
              if (TX_VALID) begin
                tx_shift_q <= TX_DATA;
              end else begin
                tx_state_q <= TX_EOP;
              end
            end
          end
        end
        TX_EOP: begin
          // Trailing stuff bit if the last byte ended in six ones
          TX_SERIAL  <= stuff ? !TX_SERIAL : TX_SERIAL;
          ones_q     <= 3'd0;
          tx_state_q <= TX_IDLE;
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

endmodule

// ==== logic/xcvr_term_pkg.sv ====
// Package: register map, field layouts and types for the line control block
package xcvr_term_pkg;

  // Register byte offsets (chosen map)
  localparam logic [7:0] FUNC_CTRL_OFS  = 8'h00;
  localparam logic [7:0] OTG_CTRL_OFS   = 8'h04;
  localparam logic [7:0] TX_BOOST_OFS   = 8'h08;
  localparam logic [7:0] LINE_STAT_OFS  = 8'h0C;

  // Function control field positions
  localparam int XCVR_SEL_LSB  = 0;
  localparam int TERM_SEL_BIT  = 2;
  localparam int OP_MODE_LSB   = 3;
  // OTG control field positions
  localparam int DP_PULL_BIT   = 1;
  localparam int DM_PULL_BIT   = 2;
  // Boost field position and width
  localparam int BOOST_LSB     = 0;
  localparam int BOOST_W       = 3;

  // Reset values
  localparam logic [4:0] FUNC_CTRL_RST = 5'h01;
  localparam logic [2:0] OTG_CTRL_RST  = 3'h6;
  localparam logic [2:0] TX_BOOST_RST  = 3'h0;

  // Field encodings
  localparam logic [1:0] XCVR_HS   = 2'h0;
  localparam logic [1:0] XCVR_FS   = 2'h1;
  localparam logic [1:0] XCVR_LS   = 2'h2;
  localparam logic [1:0] OPM_NORM  = 2'h0;
  localparam logic [1:0] OPM_TRIST = 2'h1;
  localparam logic [1:0] OPM_NODRV = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Mode control fields
  typedef struct packed {
    logic [1:0] operating_mode;
    logic       termination_select;
    logic [1:0] transceiver_select;
  } func_ctrl_t;

  // Resistor enables driven to the analog pads
  typedef struct packed {
    logic plus_line_high_pull_on;
    logic minus_line_high_pull_on;
    logic plus_line_low_pull_on;
    logic minus_line_low_pull_on;
    logic fast_line_termination_on;
  } term_en_t;

  // Transmit encoder states
  typedef enum logic [1:0] { TX_IDLE, TX_SHIFT, TX_EOP } tx_state_t;

endpackage

// ==== tb/xcvr_term_checker.sv ====
// Port checker for the termination decode and serial paths
`timescale 1ns/100ps
module xcvr_term_checker
  import xcvr_term_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic S_BVALID,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic TX_SERIAL,
  input wire logic TX_ACTIVE,
  input wire logic TX_FAST_SEL,
  input wire logic [xcvr_term_pkg::BOOST_W-1:0] TX_AMPLITUDE,
  input wire logic RX_FAST_DATA,
  input wire logic RX_FAST_SQUELCH,
  input wire logic RX_SLOW_DATA,
  input wire logic RX_PLUS_SE,
  input wire logic RX_MINUS_SE,
  input wire logic RX_SERIAL,
  input wire logic RX_SERIAL_VALID,
  input wire logic [1:0] LINE_STATE,
  input wire xcvr_term_pkg::term_en_t TERM_EN
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  // Cycles without a line toggle while sending; the first active
  // cycle still shows the idle level, so it is not counted
  logic [3:0] run_q;
  logic       last_q;
  logic       act_q;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_q  <= 4'h0;
      last_q <= 1'b1;
      act_q  <= 1'b0;
    end else begin
      last_q <= TX_SERIAL;
      act_q  <= TX_ACTIVE;
      run_q  <= (TX_ACTIVE && act_q && TX_SERIAL == last_q) ?
                run_q + 4'h1 : 4'h0;
    end
  end

  // Power-up row loads on the first edge after reset with no write behind it
  property p_term_hold;
    $changed(TERM_EN) && $past(RST_B, 2) |-> $past(S_BVALID);
  endproperty
  a_term_hold: assert property (p_term_hold)
    else $error("enables moved without a write");
  property p_amp; $changed(TX_AMPLITUDE) |-> S_BVALID || $past(S_BVALID);
  endproperty
  a_amp: assert property (p_amp) else $error("boost moved alone");
  property p_clash; $onehot0({TERM_EN[4:3], TERM_EN[0]}); endproperty
  a_clash: assert property (p_clash) else $error("pull-up clash");
  property p_rx_sel; RST_B |=> RX_SERIAL ==
    ($past(TX_FAST_SEL) ? $past(RX_FAST_DATA) : $past(RX_SLOW_DATA));
  endproperty
  a_rx_sel: assert property (p_rx_sel) else $error("wrong receiver");
  property p_line;
    RST_B |=> LINE_STATE == {$past(RX_MINUS_SE), $past(RX_PLUS_SE)};
  endproperty
  a_line: assert property (p_line) else $error("line state wrong");
  property p_sq; TX_FAST_SEL && RX_FAST_SQUELCH |=> !RX_SERIAL_VALID;
  endproperty
  a_sq: assert property (p_sq) else $error("noise accepted");
  // Valid flag resets low, so only cycles after release count
  property p_open;
    RST_B && !(TX_FAST_SEL && RX_FAST_SQUELCH) |=> RX_SERIAL_VALID;
  endproperty
  a_open: assert property (p_open) else $error("data dropped");
  property p_take; TX_VALID && TX_READY |=> TX_ACTIVE && !TX_READY;
  endproperty
  a_take: assert property (p_take) else $error("byte not sent");
  property p_stuff; run_q <= 4'h6; endproperty
  a_stuff: assert property (p_stuff) else $error("stuff bit missing");

  // Main scenarios reached
  c_write: cover property (S_BVALID);
  c_fast: cover property (TERM_EN.fast_line_termination_on);
  c_stuff: cover property (run_q == 4'h6);
endmodule

bind xcvr_term xcvr_term_checker chk (
  .CLK, .RST_B, .S_BVALID, .TX_VALID, .TX_READY, .TX_SERIAL, .TX_ACTIVE,
  .TX_FAST_SEL, .TX_AMPLITUDE, .RX_FAST_DATA, .RX_FAST_SQUELCH,
  .RX_SLOW_DATA, .RX_PLUS_SE, .RX_MINUS_SE, .RX_SERIAL, .RX_SERIAL_VALID,
  .LINE_STATE, .TERM_EN
);

// ==== tb/line_partner.sv ====
// Far-end model: cable receiver levels, fresh each cycle
`timescale 1ns/100ps
module line_partner (
  input  wire logic clk,
  output logic      fast_data,
  output logic      squelch,
  output logic      slow_data,
  output logic      plus_se,
  output logic      minus_se
);
  // Noise and squelch alike; a stale level would hide a wrong pick
  always @(posedge clk)
    {fast_data, squelch, slow_data, plus_se, minus_se} <= 5'($urandom);
endmodule

// ==== tb/usb_termination_mode_decode_test.sv ====
// Self-checking bench for the termination decode block
`timescale 1ns/100ps
module usb_termination_mode_decode_test;
  import xcvr_term_pkg::*;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0]  resp;
  } note_t;
  logic        clk, rst_b, aw_valid, w_valid, ar_valid, tx_valid, tx_ready;
  logic        aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic        rx_fd, rx_sq, rx_sd, rx_p, rx_m;
  logic [7:0]  aw_addr, ar_addr, tx_data;
  logic [31:0] w_data, r_data, v;
  logic [3:0]  w_strb;
  logic [1:0]  b_resp, r_resp;
  logic        tx_act, tx_ser, fast, lvl_q, act_q;
  logic [BOOST_W-1:0] amp;
  logic [7:0]  got, tq[$];
  term_en_t    en;
  int          nbit, ones;
  int          mismatches, n_tests;
  note_t       bq[$], rq[$];
  // Mode table: function bits, pull requests, expected enables
  logic [12:0] tbl [22] = '{
    {5'h0C,3'h6,5'h00}, {5'h0F,3'h2,5'h00}, {5'h01,3'h6,5'h06},
    {5'h10,3'h6,5'h07}, {5'h00,3'h6,5'h07}, {5'h07,3'h6,5'h06},
    {5'h16,3'h6,5'h06}, {5'h15,3'h6,5'h06}, {5'h14,3'h0,5'h10},
    {5'h05,3'h0,5'h10}, {5'h00,3'h0,5'h01}, {5'h10,3'h0,5'h01},
    {5'h06,3'h0,5'h08}, {5'h16,3'h0,5'h08}, {5'h14,3'h4,5'h12},
    {5'h15,3'h4,5'h12}, {5'h00,3'h4,5'h03}, {5'h10,3'h4,5'h03},
    {5'h18,3'h6,5'h00}, {5'h05,3'h2,5'h00}, {5'h04,3'h0,5'h00},
    {5'h06,3'h4,5'h00}};

  xcvr_term uut (
    .CLK(clk), .RST_B(rst_b), .S_AWADDR(aw_addr), .S_AWVALID(aw_valid),
    .S_AWREADY(aw_ready), .S_WDATA(w_data), .S_WSTRB(w_strb),
    .S_WVALID(w_valid), .S_WREADY(w_ready), .S_BRESP(b_resp),
    .S_BVALID(b_valid), .S_BREADY(1'b1), .S_ARADDR(ar_addr),
    .S_ARVALID(ar_valid), .S_ARREADY(ar_ready), .S_RDATA(r_data),
    .S_RRESP(r_resp), .S_RVALID(r_valid), .S_RREADY(1'b1),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .TX_SERIAL(tx_ser), .TX_ACTIVE(tx_act), .TX_FAST_SEL(fast),
    .TX_AMPLITUDE(amp),
    .RX_FAST_DATA(rx_fd), .RX_FAST_SQUELCH(rx_sq), .RX_SLOW_DATA(rx_sd),
    .RX_PLUS_SE(rx_p), .RX_MINUS_SE(rx_m), .RX_SERIAL(),
    .RX_SERIAL_VALID(), .LINE_STATE(), .TERM_EN(en));
  line_partner far_end (
    .clk(clk), .fast_data(rx_fd), .squelch(rx_sq), .slow_data(rx_sd),
    .plus_se(rx_p), .minus_se(rx_m));

  always #10 clk = ~clk;

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g, input logic [31:0] m);
    n_tests++;
    if ((g & m) !== (e & m)) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e & m, g & m);
    end
  endtask

  // Watcher: each answer against the oldest note
  always @(posedge clk) begin
    if (b_valid === 1'b1) begin
      check("bresp", {30'h0, bq[0].resp}, {30'h0, b_resp}, 32'h3);
      void'(bq.pop_front());
    end
    if (r_valid === 1'b1) begin
      check("rdata", rq[0].data, r_data, rq[0].mask);
      check("rresp", {30'h0, rq[0].resp}, {30'h0, r_resp}, 32'h3);
      void'(rq.pop_front());
    end
  end

  // Serial watcher: undo NRZI and stuffing, oldest sent byte is the note;
  // act_q skips the first active cycle, which still shows the idle level
  always @(posedge clk) begin
    if (tx_act && act_q) begin
      if (ones == 6) begin
        ones = 0;
      end else begin
        got = {tx_ser == lvl_q, got[7:1]};
        ones = (tx_ser == lvl_q) ? ones + 1 : 0;
        nbit++;
        if (nbit == 8) begin
          nbit = 0;
          check("serial", {24'h0, tq[0]}, {24'h0, got}, 32'hFF);
          void'(tq.pop_front());
        end
      end
    end
    lvl_q <= tx_ser;
    act_q <= tx_act;
  end

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    bq.push_back('{32'h0, 32'h0, r});
    aw_addr <= a;
    w_data <= d;
    w_strb <= s;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_ready) aw_valid <= 1'b0;
      if (w_ready) w_valid <= 1'b0;
    end while ((aw_valid && !aw_ready) || (w_valid && !w_ready));
    do @(posedge clk); while (b_valid !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic [1:0] r);
    rq.push_back('{d, m, r});
    ar_addr <= a;
    ar_valid <= 1'b1;
    do @(posedge clk); while (ar_ready !== 1'b1);
    ar_valid <= 1'b0;
    do @(posedge clk); while (r_valid !== 1'b1);
  endtask

  task automatic send(input logic [7:0] b);
    tq.push_back(b);
    tx_data <= b;
    tx_valid <= 1'b1;
    do @(posedge clk); while (tx_ready !== 1'b1);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("mismatch watchdog expected done seen hang");
    wrap_up();
  end

  initial begin
    {clk, rst_b, aw_valid, w_valid, ar_valid, tx_valid} = 6'h00;
    {aw_addr, ar_addr, tx_data, w_data} = 56'h0;
    w_strb = 4'hF;
    mismatches = 0;
    n_tests = 0;
    v = $urandom(32'h072A03B8);
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(FUNC_CTRL_OFS, 32'h1, 32'hFFFFFFFF, RESP_OKAY);
    rd(OTG_CTRL_OFS, 32'h6, 32'h6, RESP_OKAY);
    rd(LINE_STAT_OFS, 32'h06, 32'h1F, RESP_OKAY);
    $display("test reset done");
    foreach (tbl[i]) begin
      wr(FUNC_CTRL_OFS, {27'h0, tbl[i][12:8]}, 4'hF, RESP_OKAY);
      wr(OTG_CTRL_OFS, {29'h0, tbl[i][7:5]}, 4'hF, RESP_OKAY);
      rd(LINE_STAT_OFS, {27'h0, tbl[i][4:0]}, 32'h1F, RESP_OKAY);
      check("enables", {27'h0, tbl[i][4:0]}, {27'h0, en}, 32'h1F);
      v = {31'h0, tbl[i][9:8] == XCVR_HS};
      check("fast_sel", v, {31'h0, fast}, 32'h1);
    end
    $display("test mode table done");
    // Strobe off: write ignored, enables hold
    wr(FUNC_CTRL_OFS, 32'h0C, 4'h0, RESP_OKAY);
    rd(FUNC_CTRL_OFS, 32'h06, 32'hFFFFFFFF, RESP_OKAY);
    wr(8'h10, $urandom, 4'hF, RESP_SLVERR);
    rd(8'h10, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    $display("test hold and unmapped done");
    repeat (4) begin
      v = $urandom;
      wr(TX_BOOST_OFS, v, 4'hF, RESP_OKAY);
      rd(TX_BOOST_OFS, {29'h0, v[2:0]}, 32'hFFFFFFFF, RESP_OKAY);
      check("amplitude", v, {29'h0, amp}, 32'h7);
    end
    $display("test boost done");
    wr(FUNC_CTRL_OFS, 32'h00, 4'hF, RESP_OKAY);
    // Runs of ones across bytes force stuffing
    send(8'hFF);
    send(8'hFF);
    send(8'($urandom));
    send(8'h00);
    tx_valid <= 1'b0;
    repeat (12) @(posedge clk);
    check("bytes_left", 32'h0, tq.size(), 32'hFF);
    $display("test transmit done");
    wrap_up();
  end
endmodule
